// >>> rtl/sphs_defines.svh
// sphs_defines.svh: offsets, bit positions and codes of the strobed handshake status port
// assumes: included by the design files by bare name
//
// Functional notes
// RULE1 - four 8-bit read/write status words at offsets 02, 06, 0A, 0E hex
// RULE2 - with group A strobed input, lines 7 and 6 stay general-purpose I/O
// RULE3 - host changes spare output lines only by the single-bit set/reset command; the code also takes a whole-byte write when host_bsr is low
// RULE4 - bit 5 high when port A latch loaded; bit 1 same for port B
// RULE5 - bit 4 is port A request enable, driven by set/reset of line 4
// RULE6 - bit 3 is port A request flag, active only while its enable is high
// RULE7 - port A request flag means captured data waits for the host
// RULE8 - set request flag plus global enable plus control bit means interrupt pending
// RULE9 - bit 2 is port B request enable, driven by set/reset of line 2
// RULE10 - bit 0 is port B request flag, captured data waits for the host
// RULE11 - strobe input levels never appear in the returned status bits
// RULE12 - with group A strobed output, lines 4 and 5 stay general-purpose I/O
// RULE13 - with both groups strobed, no spare lines remain for group B
// RULE14 - strobed output read returns the output-mode status layout
// RULE15 - input and output status layouts differ
// RULE16 - host programs don't-care control bits to suit other port uses
// RULE17 - one control word sets or clears any single third-port line
// RULE18 - port B request flag gated by port B's own enable
`ifndef SPHS_DEFINES_SVH
`define SPHS_DEFINES_SVH
`define SPHS_OFS_GRP0        8'h02
`define SPHS_OFS_GRP1        8'h06
`define SPHS_OFS_GRP2        8'h0a
`define SPHS_OFS_GRP3        8'h0e
`define SPHS_NGRP            4
`define SPHS_IN_SPARE_HI     7
`define SPHS_IN_SPARE_LO     6
`define SPHS_IN_FULL_A       5
`define SPHS_IN_ENA_A        4
`define SPHS_REQ_A           3
`define SPHS_ENA_B           2
`define SPHS_FULL_B          1
`define SPHS_REQ_B           0
`define SPHS_OUT_FULL_A_N    7
`define SPHS_OUT_ENA_A       6
`define SPHS_OUT_SPARE_HI    5
`define SPHS_OUT_SPARE_LO    4
`define SPHS_BSR_BIT         7
`define SPHS_BSR_VAL         0
`define SPHS_BSR_SEL_HI      3
`define SPHS_BSR_SEL_LO      1
`define SPHS_RST_BYTE        8'h00
`endif

// >>> rtl/sphs_pkg.sv
// sphs_pkg.sv: types for the strobed handshake status port
// assumes: sphs_defines.svh on the include path
`default_nettype none
package sphs_pkg;
    typedef enum logic [2:0] {
        SPHS_IDLE  = 3'b001,
        SPHS_FULL  = 3'b010,
        SPHS_DRAIN = 3'b100
    } sphs_state_t;

    // per-group configuration and live state
    typedef struct packed {
        logic a_strobed;
        logic a_output;
        logic b_strobed;
        logic b_output;
    } sphs_cfg_t;

    typedef struct packed {
        logic       hs_a;
        logic       hs_b;
        logic [7:0] lines;
    } sphs_grp_t;
endpackage
`default_nettype wire

// >>> rtl/sphs_stat_mem.sv
// sphs_stat_mem.sv: small registered-read store of one byte per group
// assumes: single clock, synchronous active-high reset
`default_nettype none
`include "sphs_defines.svh"
module sphs_stat_mem
    import sphs_pkg::*;
#(
    parameter int DEPTH = `SPHS_NGRP,
    parameter int AW    = 2
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    // read side
    input  wire logic [AW-1:0] rd_addr,
    output var  logic [7:0]    rd_data
);
    logic [7:0] mem_reg [DEPTH];

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= `SPHS_RST_BYTE;
            end
        end else if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rd_data <= `SPHS_RST_BYTE;
        end else begin
            rd_data <= mem_reg[rd_addr];
        end
    end
endmodule // sphs_stat_mem
`default_nettype wire

// >>> rtl/sphs_top.sv
// sphs_top.sv: handshake status words of four parallel groups in strobed mode
// assumes: host bus is a simple synchronous 8-bit strobe port; strobes synchronous
`default_nettype none
`include "sphs_defines.svh"
module sphs_top
    import sphs_pkg::*;
#(
    parameter int NGRP = `SPHS_NGRP
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // host register port
    input  wire logic             host_wr,
    input  wire logic             host_rd,
    input  wire logic             host_bsr,
    input  wire logic [7:0]       host_addr,
    input  wire logic [7:0]       host_wdata,
    output var  logic [7:0]       host_rdata,
    output var  logic             host_rvalid,
    output var  logic             host_err,
    // group configuration and interrupt control
    input  wire sphs_cfg_t [NGRP-1:0] cfg,
    input  wire logic             global_interrupt_enable,
    input  wire logic [2*NGRP-1:0] irq_ctrl_two,
    // strobes and data-taken acknowledges per group
    input  wire logic [NGRP-1:0]  first_strobe_in_n,
    input  wire logic [NGRP-1:0]  second_strobe_in_n,
    input  wire logic [NGRP-1:0]  first_data_taken,
    input  wire logic [NGRP-1:0]  second_data_taken,
    // spare line pins
    input  wire logic [7:0]       spare_in [NGRP],
    output var  logic [7:0]       spare_out [NGRP],
    output var  logic [7:0]       spare_oe [NGRP],
    // interrupt pending per port
    output var  logic [2*NGRP-1:0] irq_pending
);
    ////////////////////////////////////////////////////////////////////////
    // address decode
    function automatic logic [2:0] grp_of(input logic [7:0] a);
        unique case (a)
            `SPHS_OFS_GRP0: grp_of = 3'h4;
            `SPHS_OFS_GRP1: grp_of = 3'h5;
            `SPHS_OFS_GRP2: grp_of = 3'h6;
            `SPHS_OFS_GRP3: grp_of = 3'h7;
            default:        grp_of = 3'h0;
        endcase
    endfunction

    logic [2:0] dec;
    logic       hit;
    logic [1:0] gsel;
    // RULE1 four status offsets
    assign dec  = grp_of(host_addr);
    assign hit  = dec[2];
    assign gsel = dec[1:0];

    ////////////////////////////////////////////////////////////////////////
    // per-group state
    logic [7:0]  lat_reg   [NGRP];
    logic [NGRP-1:0] full_a_reg, full_b_reg, ena_a_reg, ena_b_reg;
    logic [NGRP-1:0] stb_a_d_reg, stb_b_d_reg;
    sphs_state_t st_a_reg [NGRP];
    logic [7:0]  stat_word [NGRP];

    // RULE17 single line set/reset decode
    function automatic logic [7:0] bsr_apply(input logic [7:0] cur, input logic [7:0] cw);
        logic [7:0] r;
        r = cur;
        r[cw[`SPHS_BSR_SEL_HI:`SPHS_BSR_SEL_LO]] = cw[`SPHS_BSR_VAL];
        return r;
    endfunction

    always_ff @(posedge clock) begin
        if (rst) begin
            stb_a_d_reg <= '1;
            stb_b_d_reg <= '1;
        end else begin
            stb_a_d_reg <= first_strobe_in_n;
            stb_b_d_reg <= second_strobe_in_n;
        end
    end

    for (genvar g = 0; g < NGRP; g++) begin : grp
        logic sel_wr, sel_bsr, fall_a, fall_b;
        logic [7:0] lines_next;
        assign sel_wr  = host_wr && hit && gsel == 2'(g) && !host_bsr;
        assign sel_bsr = host_wr && hit && gsel == 2'(g) && host_bsr
                         && !host_wdata[`SPHS_BSR_BIT];
        assign fall_a  = stb_a_d_reg[g] && !first_strobe_in_n[g];
        assign fall_b  = stb_b_d_reg[g] && !second_strobe_in_n[g];
        assign lines_next = sel_bsr ? bsr_apply(lat_reg[g], host_wdata) :
                            sel_wr  ? host_wdata : lat_reg[g];

        // spare line latch; RULE3 set/reset updates it, and a whole-byte write does too when host_bsr is low
        always_ff @(posedge clock) begin
            if (rst) begin
                lat_reg[g] <= `SPHS_RST_BYTE;
            end else begin
                lat_reg[g] <= lines_next;
            end
        end

        // RULE5 enable A on line four in input mode, line six in output mode
        always_ff @(posedge clock) begin
            if (rst) begin
                ena_a_reg[g] <= 1'b0;
                ena_b_reg[g] <= 1'b0;
            end else begin
                ena_a_reg[g] <= cfg[g].a_output ? lines_next[`SPHS_OUT_ENA_A]
                                                : lines_next[`SPHS_IN_ENA_A];
                // RULE9 enable B on line two
                ena_b_reg[g] <= lines_next[`SPHS_ENA_B];
            end
        end

        // RULE4 latch full; set wins over host take
        always_ff @(posedge clock) begin
            if (rst) begin
                st_a_reg[g]   <= SPHS_IDLE;
                full_b_reg[g] <= 1'b0;
            end else begin
                unique case (st_a_reg[g])
                    SPHS_IDLE:  if (cfg[g].a_strobed && fall_a) begin
                                    st_a_reg[g] <= SPHS_FULL;
                                end
                    SPHS_FULL:  if (first_data_taken[g] && !(cfg[g].a_strobed && fall_a)) begin
                                    st_a_reg[g] <= SPHS_DRAIN;
                                end
                    SPHS_DRAIN: st_a_reg[g] <= (cfg[g].a_strobed && fall_a) ? SPHS_FULL : SPHS_IDLE;
                    default:    st_a_reg[g] <= SPHS_IDLE;
                endcase
                if (cfg[g].b_strobed && fall_b) begin
                    full_b_reg[g] <= 1'b1;
                end else if (second_data_taken[g]) begin
                    full_b_reg[g] <= 1'b0;
                end
            end
        end
        assign full_a_reg[g] = st_a_reg[g] == SPHS_FULL;

        logic req_a, req_b;
        // RULE6 RULE7 request A gated by enable
        assign req_a = full_a_reg[g] && ena_a_reg[g];
        // RULE10 RULE18 request B gated by own enable
        assign req_b = full_b_reg[g] && ena_b_reg[g];

        // RULE11 RULE14 RULE15 layout by direction, no strobe levels
        always_comb begin
            stat_word[g] = 8'h00;
            if (cfg[g].a_output) begin
                stat_word[g][`SPHS_OUT_FULL_A_N] = !full_a_reg[g];
                stat_word[g][`SPHS_OUT_ENA_A]    = ena_a_reg[g];
                // RULE12 spare lines four and five
                stat_word[g][`SPHS_OUT_SPARE_HI] = spare_in[g][`SPHS_OUT_SPARE_HI];
                stat_word[g][`SPHS_OUT_SPARE_LO] = spare_in[g][`SPHS_OUT_SPARE_LO];
            end else begin
                // RULE2 spare lines seven and six
                stat_word[g][`SPHS_IN_SPARE_HI] = spare_in[g][`SPHS_IN_SPARE_HI];
                stat_word[g][`SPHS_IN_SPARE_LO] = spare_in[g][`SPHS_IN_SPARE_LO];
                stat_word[g][`SPHS_IN_FULL_A]   = full_a_reg[g];
                stat_word[g][`SPHS_IN_ENA_A]    = ena_a_reg[g];
            end
            stat_word[g][`SPHS_REQ_A]  = req_a;
            stat_word[g][`SPHS_ENA_B]  = ena_b_reg[g];
            stat_word[g][`SPHS_FULL_B] = cfg[g].b_output ? !full_b_reg[g] : full_b_reg[g];
            stat_word[g][`SPHS_REQ_B]  = req_b;
        end

        // RULE13 only group A spares drive pins; none left for B
        always_ff @(posedge clock) begin
            if (rst) begin
                spare_out[g] <= `SPHS_RST_BYTE;
                spare_oe[g]  <= `SPHS_RST_BYTE;
            end else begin
                spare_out[g] <= lines_next;
                spare_oe[g]  <= 8'h00;
                if (cfg[g].a_output) begin
                    spare_oe[g][`SPHS_OUT_SPARE_HI] <= 1'b1;
                    spare_oe[g][`SPHS_OUT_SPARE_LO] <= 1'b1;
                end else begin
                    spare_oe[g][`SPHS_IN_SPARE_HI] <= 1'b1;
                    spare_oe[g][`SPHS_IN_SPARE_LO] <= 1'b1;
                end
            end
        end

        // RULE8 pending needs global enable and control bit
        always_ff @(posedge clock) begin
            if (rst) begin
                irq_pending[2*g]   <= 1'b0;
                irq_pending[2*g+1] <= 1'b0;
            end else begin
                irq_pending[2*g]   <= req_a && global_interrupt_enable && irq_ctrl_two[2*g];
                irq_pending[2*g+1] <= req_b && global_interrupt_enable
                                      && irq_ctrl_two[2*g+1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path: status word registered straight into host_rdata; store output unused
    logic [7:0] snap;
    assign snap = stat_word[gsel];

    sphs_stat_mem #(.DEPTH(NGRP), .AW(2)) u_mem (
        .clock   (clock),
        .rst     (rst),
        .wr_en   (host_rd && hit),
        .wr_addr (gsel),
        .wr_data (snap),
        .rd_addr (gsel),
        .rd_data ()
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            host_rdata  <= `SPHS_RST_BYTE;
            host_rvalid <= 1'b0;
            host_err    <= 1'b0;
        end else begin
            host_rvalid <= host_rd;
            host_err    <= (host_rd || host_wr) && !hit;
            host_rdata  <= (host_rd && hit) ? snap : `SPHS_RST_BYTE;
        end
    end
endmodule // sphs_top
`default_nettype wire

// >>> test/sphs_top_props.sv
// sphs_top_props.sv: port checker for the strobed handshake status block
// assumes: bound onto sphs_top; group 0 carries the strobed input traffic
`default_nettype none
module sphs_top_props
    import sphs_pkg::*;
#(
    parameter int NGRP = 4
) (
    // clock and reset
    input wire logic                 clock,
    input wire logic                 rst,
    // host port
    input wire logic                 host_wr,
    input wire logic                 host_rd,
    input wire logic                 host_bsr,
    input wire logic [7:0]           host_addr,
    input wire logic [7:0]           host_wdata,
    input wire logic [7:0]           host_rdata,
    input wire logic                 host_rvalid,
    input wire logic                 host_err,
    // configuration, interrupts, spare lines
    input wire sphs_cfg_t [NGRP-1:0] cfg,
    input wire logic                 global_interrupt_enable,
    input wire logic [2*NGRP-1:0]    irq_pending,
    input wire logic [7:0]           spare_out [NGRP],
    input wire logic [7:0]           spare_oe [NGRP]
);
    logic hit;
    logic in0;
    assign hit = host_addr inside {8'h02, 8'h06, 8'h0a, 8'h0e};
    assign in0 = cfg[0].a_strobed & ~cfg[0].a_output;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_en4;
        host_wr && host_bsr && host_addr == 8'h02 && host_wdata[7:1] == 7'h04 && in0;
    endsequence
    sequence s_rd0;
        host_rd && host_addr == 8'h02 && in0;
    endsequence
    property p_map; host_rd && hit |=> host_rvalid && !host_err; endproperty
    property p_err;
        (host_rd || host_wr) && !hit |=> host_err && host_rvalid == $past(host_rd);
    endproperty
    property p_en_a; s_en4 ##2 s_rd0 |=> host_rdata[4] == $past(host_wdata[0], 3); endproperty
    property p_req_a;
        host_rvalid && $past(host_addr == 8'h02 && in0) |-> host_rdata[3] == &host_rdata[5:4];
    endproperty
    property p_req_b;
        host_rvalid && $past(host_addr == 8'h02 && in0) |-> host_rdata[0] == &host_rdata[2:1];
    endproperty
    property p_irq; (!global_interrupt_enable) [*2] |-> irq_pending == '0; endproperty
    property p_spare;
        (in0 && cfg[0].b_strobed && !cfg[0].b_output) [*2] |-> spare_oe[0][5:0] == 6'h00;
    endproperty
    property p_bsr;
        host_wr && host_bsr && host_addr == 8'h02 && !host_wdata[7] && &host_wdata[3:2] && in0
        |=> spare_out[0][$past(host_wdata[3:1])] == $past(host_wdata[0]);
    endproperty
    a_map: assert property (p_map) else $error("mapped read not answered");
    a_err: assert property (p_err) else $error("unmapped access not refused");
    a_en_a: assert property (p_en_a) else $error("enable A not set by line 4");
    a_req_a: assert property (p_req_a) else $error("request A not full and enable");
    a_req_b: assert property (p_req_b) else $error("request B not gated");
    a_irq: assert property (p_irq) else $error("pending without global enable");
    a_spare: assert property (p_spare) else $error("handshake line driven");
    a_bsr: assert property (p_bsr) else $error("spare line not set or cleared");
endmodule // sphs_top_props
bind sphs_top sphs_top_props #(.NGRP(NGRP)) sphs_top_props_i (.clock(clock), .rst(rst),
    .host_wr(host_wr), .host_rd(host_rd), .host_bsr(host_bsr), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .host_err(host_err), .cfg(cfg), .global_interrupt_enable(global_interrupt_enable),
    .irq_pending(irq_pending), .spare_out(spare_out), .spare_oe(spare_oe));
`default_nettype wire

// >>> test/sphs_periph.sv
// sphs_periph.sv: strobing peripheral on the far side of the handshake lines
// assumes: the bench holds a request bit high for as long as a strobe lasts
`default_nettype none
module sphs_periph (
    // strobe requests from the bench
    input  wire logic [3:0] pulse_a,
    input  wire logic [3:0] pulse_b,
    // active-low strobes toward the block
    output var  logic [3:0] first_strobe_in_n,
    output var  logic [3:0] second_strobe_in_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // strobes idle high, low only while asked
    always_comb begin
        first_strobe_in_n  = ~pulse_a;
        second_strobe_in_n = ~pulse_b;
    end
endmodule // sphs_periph
`default_nettype wire

// >>> test/sphs_top_tb.sv
// sphs_top_tb.sv: self-checking bench for the strobed handshake status block
// assumes: sphs_top_props bound in; peripheral model drives the strobes
`default_nettype none
module sphs_top_tb
    import sphs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clock = 1'b0;
    logic             rst = 1'b1;
    logic             host_wr, host_rd, host_bsr, host_rvalid, host_err, gie;
    logic [7:0]       host_addr, host_wdata, host_rdata, irq_pending, ictl;
    logic [3:0]       pa, pb, take_a, take_b, stb_a_n, stb_b_n;
    logic [7:0]       spare_in [4];
    logic [7:0]       spare_out [4];
    logic [7:0]       spare_oe [4];
    sphs_cfg_t [3:0]  cfg;
    int               error_cnt = 0;
    int               comparisons = 0;
    always #5 clock = ~clock;
    sphs_top sphs_top_i (.clock(clock), .rst(rst), .host_wr(host_wr), .host_rd(host_rd),
        .host_bsr(host_bsr), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .host_err(host_err), .cfg(cfg),
        .global_interrupt_enable(gie), .irq_ctrl_two(ictl), .first_strobe_in_n(stb_a_n),
        .second_strobe_in_n(stb_b_n), .first_data_taken(take_a), .second_data_taken(take_b),
        .spare_in(spare_in), .spare_out(spare_out), .spare_oe(spare_oe),
        .irq_pending(irq_pending));
    sphs_periph sphs_periph_i (.pulse_a(pa), .pulse_b(pb), .first_strobe_in_n(stb_a_n),
        .second_strobe_in_n(stb_b_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        host_wr <= 1'b1;
        host_bsr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge clock);
        host_wr <= 1'b0;
        host_bsr <= 1'b0;
    endtask
    task automatic wr_direct(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge clock);
        host_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic ok);
        @(posedge clock);
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge clock);
        host_rd <= 1'b0;
        #1;
        chk({6'h00, host_err, host_rvalid}, {6'h00, ~ok, 1'b1});
        if (ok) chk(host_rdata, exp);
    endtask
    task automatic pulse(input logic [3:0] sa, input logic [3:0] sb, input logic [3:0] ta,
                         input logic [3:0] tb);
        @(posedge clock);
        pa <= sa;
        pb <= sb;
        take_a <= ta;
        take_b <= tb;
        @(posedge clock);
        pa <= 4'h0;
        pb <= 4'h0;
        take_a <= 4'h0;
        take_b <= 4'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_map();
        rd(8'h02, 8'h00, 1'b1);
        rd(8'h06, 8'h00, 1'b1);
        rd(8'h0a, 8'h80, 1'b1);
        @(posedge clock);
        pa <= 4'h8;
        pb <= 4'h8;
        rd(8'h0e, 8'h00, 1'b1);
        @(posedge clock);
        pa <= 4'h0;
        pb <= 4'h0;
        rd(8'h03, 8'h00, 1'b0);
        wr_direct(8'h06, 8'h14);
        rd(8'h06, 8'h14, 1'b1);
        wr_direct(8'h05, 8'hff);
        #1 chk({7'h00, host_err}, 8'h01);
        $display("test map done");
    endtask
    task automatic t_in();
        wr(8'h02, 8'h09);
        rd(8'h02, 8'h10, 1'b1);
        wr(8'h02, 8'h05);
        rd(8'h02, 8'h14, 1'b1);
        wr(8'h02, 8'h0f);
        wr(8'h02, 8'h0e);
        pulse(4'h1, 4'h1, 4'h0, 4'h0);
        rd(8'h02, 8'h3f, 1'b1);
        chk(irq_pending, 8'h03);
        @(posedge clock);
        ictl <= 8'hfe;
        repeat (2) @(posedge clock);
        #1 chk(irq_pending, 8'h02);
        @(posedge clock);
        ictl <= 8'hff;
        wr(8'h02, 8'h04);
        rd(8'h02, 8'h3a, 1'b1);
        chk(irq_pending, 8'h01);
        @(posedge clock);
        gie <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk(irq_pending, 8'h00);
        pulse(4'h0, 4'h0, 4'h1, 4'h0);
        rd(8'h02, 8'h12, 1'b1);
        wr(8'h02, 8'h85);
        rd(8'h02, 8'h12, 1'b1);
        pulse(4'h0, 4'h0, 4'h0, 4'h1);
        rd(8'h02, 8'h10, 1'b1);
        pulse(4'h1, 4'h0, 4'h0, 4'h0);
        pulse(4'h1, 4'h1, 4'h1, 4'h1);
        rd(8'h02, 8'h3a, 1'b1);
        @(posedge clock);
        spare_in[0] <= 8'hff;
        rd(8'h02, 8'hfa, 1'b1);
        $display("test input done");
    endtask
    task automatic t_out();
        wr(8'h0a, 8'h0d);
        spare_in[2] <= 8'hff;
        rd(8'h0a, 8'hf0, 1'b1);
        wr(8'h0a, 8'h0b);
        #1 chk({7'h00, spare_out[2][5]}, 8'h01);
        chk(spare_oe[2], 8'h30);
        $display("test output done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {host_wr, host_rd, host_bsr, host_addr, host_wdata} = '0;
        {pa, pb, take_a, take_b} = '0;
        gie = 1'b1;
        ictl = 8'hff;
        spare_in = '{default: 8'h00};
        cfg = {4'b0000, 4'b1100, 4'b0000, 4'b1010};
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_map();
        t_in();
        t_out();
        report_and_stop();
    end
    initial begin
        repeat (3000) @(posedge clock);
        error_cnt++;
        report_and_stop();
    end
endmodule // sphs_top_tb
`default_nettype wire
